// file: design/tape_seq_defs.svh
// offsets, codes, field positions and reset values for the tape sequencer
`ifndef TAPE_SEQ_DEFS_SVH
`define TAPE_SEQ_DEFS_SVH
`define OFS_CMD 4'h0
`define OFS_INSTR 4'h1
`define OFS_BREG 4'h2
`define OFS_PREG 4'h3
`define OFS_CREG 4'h4
`define OFS_STATUS 4'h5
`define OFS_CW_LO 4'h6
`define OFS_CW_HI 4'h7
`define CMD_START_BIT 3
`define CMD_CLR_EOT_BIT 4
`define CMD_MOD_BIT 8
`define OP_READ_PREFACE 3'h1
`define OP_IW_FIXED 3'h2
`define OP_IW_PREFACE 3'h3
`define SIGN_CTRL_BLOCK 4'h7
`define BLOCKS_ZERO 7'h0a
`define WORDS_ZERO 7'h64
`define WORDS_MIN 7'h0a
`define WORDS_MAX 7'h64
`define MAX_RETRIES 2'h2
`define REG_RESET 32'h0
`define ADDR_RESET 16'h0
`define MEM_LAST_ADDR 16'h9999
`endif

// file: design/tape_seq_pkg.sv
// types shared by the tape block sequencer
package tape_seq_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'h0,
    st_rd_go = 4'h1,
    st_rd_word = 4'h3,
    st_rd_store = 4'h2,
    st_rd_end = 4'h6,
    st_wr_pref = 4'h7,
    st_wr_go = 4'h5,
    st_wr_fetch = 4'h4,
    st_wr_send = 4'hc,
    st_wr_next = 4'hd
  } seq_state_e;
  typedef enum logic [2:0] {
    alarm_none = 3'h0,
    alarm_no_addr = 3'h1,
    alarm_parity = 3'h2,
    alarm_eot = 3'h3,
    alarm_count = 3'h4,
    alarm_length = 3'h5,
    alarm_no_write = 3'h6,
    alarm_not_ready = 3'h7
  } alarm_cause_e;
endpackage

// file: design/tape_seq.sv
// tape block sequencer: read with preface and the two initial writes
//
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`include "tape_seq_defs.svh"
module tape_seq (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // core storage
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [43:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [43:0] mem_rdata,
  // tape unit control and status
  output logic [3:0] unit_sel,
  output logic tape_fwd,
  output logic tape_back,
  output logic tape_write_mode,
  input wire logic unit_ready,
  input wire logic unit_write_ok,
  input wire logic unit_eot_mark,
  // tape read stream
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [43:0] rd_word,
  input wire logic rd_digit_ok,
  input wire logic rd_parity_err,
  input wire logic rd_eot_block,
  input wire logic rd_block_end,
  // tape write stream
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [43:0] wr_word,
  output logic wr_block_end
);
  tape_seq_pkg::seq_state_e state;
  tape_seq_pkg::alarm_cause_e alarm;
  logic [31:0] cmd;
  logic [31:0] instr;
  logic [15:0] breg;
  logic [15:0] preg;
  logic [15:0] creg;
  logic [15:0] saved_c;
  logic [43:0] cw;
  logic [43:0] cw_mod;
  logic [15:0] addr;
  logic [15:0] blk_start;
  logic [6:0] blocks;
  logic [6:0] kk;
  logic [6:0] wi;
  logic [1:0] tries;
  logic [2:0] op;
  logic busy;
  logic eot_ind;
  logic eot_seen;
  logic count_bad;
  logic parity_seen;
  logic ctl_blk;
  logic eot_blk;
  logic ack;
  logic acc;
  logic start;
  logic no_addr;
  logic [6:0] kk_fixed;
  logic [6:0] n_dec;
  logic [31:0] status;

  // four-digit bcd sum, carry out of the top digit dropped
  function automatic logic [15:0] bcd_add(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] r;
    logic [4:0] s;
    logic c;
    r = 16'h0;
    c = 1'b0;
    for (int i = 0; i < 4; i++) begin
      s = {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + {4'h0, c};
      c = (s > 5'h09);
      if (c) begin
        s = s + 5'h06;
      end
      r[4*i+:4] = s[3:0];
    end
    return r;
  endfunction

  // two bcd digits to a count, 00 read as one hundred
  function automatic logic [6:0] bcd2_count(input logic [7:0] d);
    logic [6:0] v;
    v = 7'(d[7:4]) * 7'h0a + 7'(d[3:0]);
    return (v == 7'h0) ? `WORDS_ZERO : v;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i+:8] = nw[8*i+:8];
      end
    end
    return r;
  endfunction

  // word from tape on its way to storage
  function automatic logic [43:0] word_mod(input logic [43:0] w, input logic en,
                                           input logic [15:0] b);
    logic [43:0] r;
    r = w;
    if (en && w[43]) begin
      r[15:0] = bcd_add(w[15:0], b);
      r[43] = 1'b0;
    end
    return r;
  endfunction

  // avalon: one wait cycle, answer on the second
  assign acc = (avs_read || avs_write) && !ack;
  assign avs_waitrequest = acc;
  assign start = ack && avs_write && (avs_address[5:2] == `OFS_CMD) && avs_byteenable[0]
    && avs_writedata[`CMD_START_BIT] && !busy;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= acc;
    end
  end

  assign status = {saved_c, 8'h0, eot_ind, 1'b0, alarm, 2'h0, busy};

  // read data captured while waitrequest is high, unmapped reads give zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= `REG_RESET;
    end else if (acc && avs_read) begin
      unique case (avs_address[5:2])
        `OFS_CMD: avs_readdata <= cmd;
        `OFS_INSTR: avs_readdata <= instr;
        `OFS_BREG: avs_readdata <= {16'h0, breg};
        `OFS_PREG: avs_readdata <= {16'h0, preg};
        `OFS_CREG: avs_readdata <= {16'h0, creg};
        `OFS_STATUS: avs_readdata <= status;
        `OFS_CW_LO: avs_readdata <= cw[31:0];
        `OFS_CW_HI: avs_readdata <= {20'h0, cw[43:32]};
        default: avs_readdata <= `REG_RESET;
      endcase
    end
  end

  // software-owned configuration registers, start bit not stored
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd <= `REG_RESET;
      instr <= `REG_RESET;
      breg <= `ADDR_RESET;
      creg <= `ADDR_RESET;
    end else if (ack && avs_write && !busy) begin
      unique case (avs_address[5:2])
        `OFS_CMD: cmd <= merge(cmd, avs_writedata & 32'hffff_ffe7, avs_byteenable);
        `OFS_INSTR: instr <= merge(instr, avs_writedata, avs_byteenable);
        `OFS_BREG: breg <= 16'(merge({16'h0, breg}, avs_writedata, avs_byteenable));
        `OFS_CREG: creg <= 16'(merge({16'h0, creg}, avs_writedata, avs_byteenable));
        default: ;
      endcase
    end
  end

  // decoded instruction fields
  // zero blocks means ten
  assign n_dec = (instr[27:24] == 4'h0) ? `BLOCKS_ZERO : {3'h0, instr[27:24]};
  // words field 00 means one hundred
  assign kk_fixed = bcd2_count(instr[23:16]);
  assign cw_mod = cw[40] ? {cw[43:16], bcd_add(cw[15:0], breg)} : cw;
  // a storage access beyond the last location stops the instruction
  assign no_addr = (addr > `MEM_LAST_ADDR);
  assign mem_req = !no_addr && ((state == tape_seq_pkg::st_rd_store)
    || (state == tape_seq_pkg::st_wr_pref) || (state == tape_seq_pkg::st_wr_fetch));
  assign mem_we = (state == tape_seq_pkg::st_rd_store);
  assign mem_addr = addr;
  assign rd_ready = (state == tape_seq_pkg::st_rd_word);

  // end-of-tape indicator, a marker seen in the same cycle wins over clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eot_ind <= 1'b0;
    end else if (state == tape_seq_pkg::st_wr_next && eot_seen
                 && (blocks == 7'h1 || op == `OP_IW_FIXED)) begin
      eot_ind <= 1'b1;
    end else if (ack && avs_write && avs_address[5:2] == `OFS_CMD && avs_byteenable[0]
                 && avs_writedata[`CMD_CLR_EOT_BIT]) begin
      eot_ind <= 1'b0;
    end
  end

  // main sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= tape_seq_pkg::st_idle;
      alarm <= tape_seq_pkg::alarm_none;
      busy <= 1'b0;
      op <= 3'h0;
      preg <= `ADDR_RESET;
      saved_c <= `ADDR_RESET;
      cw <= 44'h0;
      addr <= `ADDR_RESET;
      blk_start <= `ADDR_RESET;
      blocks <= 7'h0;
      kk <= 7'h0;
      wi <= 7'h0;
      tries <= 2'h0;
      eot_seen <= 1'b0;
      count_bad <= 1'b0;
      parity_seen <= 1'b0;
      ctl_blk <= 1'b0;
      eot_blk <= 1'b0;
      mem_wdata <= 44'h0;
      wr_word <= 44'h0;
      wr_valid <= 1'b0;
      tape_fwd <= 1'b0;
      tape_back <= 1'b0;
      wr_block_end <= 1'b0;
      unit_sel <= 4'h0;
      tape_write_mode <= 1'b0;
    end else begin
      tape_fwd <= 1'b0;
      tape_back <= 1'b0;
      wr_block_end <= 1'b0;
      if (ack && avs_write && avs_address[5:2] == `OFS_PREG && !busy) begin
        preg <= 16'(merge({16'h0, preg}, avs_writedata, avs_byteenable));
      end
      if (busy && unit_eot_mark && tape_write_mode) begin
        eot_seen <= 1'b1;
      end
      if (busy && !unit_ready) begin
        alarm <= tape_seq_pkg::alarm_not_ready;
        busy <= 1'b0;
        wr_valid <= 1'b0;
        state <= tape_seq_pkg::st_idle;
      end else if (busy && no_addr) begin
        alarm <= tape_seq_pkg::alarm_no_addr;
        busy <= 1'b0;
        wr_valid <= 1'b0;
        state <= tape_seq_pkg::st_idle;
      end else begin
        unique case (state)
          tape_seq_pkg::st_idle: begin
            if (start) begin
              op <= avs_writedata[2:0];
              unit_sel <= avs_writedata[7:4];
              addr <= instr[28] ? bcd_add(instr[15:0], breg) : instr[15:0];
              blocks <= n_dec;
              tries <= 2'h0;
              eot_seen <= 1'b0;
              alarm <= tape_seq_pkg::alarm_none;
              tape_write_mode <= (avs_writedata[2:0] != `OP_READ_PREFACE);
              busy <= 1'b1;
              if (!unit_ready) begin
                alarm <= tape_seq_pkg::alarm_not_ready;
                busy <= 1'b0;
              end else if (eot_ind) begin
                // indicator still set means no backward move was made
                alarm <= tape_seq_pkg::alarm_eot;
                busy <= 1'b0;
              end else if (avs_writedata[2:0] == `OP_READ_PREFACE) begin
                state <= tape_seq_pkg::st_rd_go;
              end else if (!unit_write_ok) begin
                alarm <= tape_seq_pkg::alarm_no_write;
                busy <= 1'b0;
              end else if (avs_writedata[2:0] == `OP_IW_PREFACE) begin
                state <= tape_seq_pkg::st_wr_pref;
              end else if (avs_writedata[2:0] == `OP_IW_FIXED) begin
                kk <= kk_fixed;
                if (kk_fixed < `WORDS_MIN) begin
                  alarm <= tape_seq_pkg::alarm_length;
                  busy <= 1'b0;
                end else begin
                  state <= tape_seq_pkg::st_wr_go;
                end
              end else begin
                busy <= 1'b0;
              end
            end
          end
          tape_seq_pkg::st_rd_go: begin
            tape_fwd <= 1'b1;
            blk_start <= addr;
            wi <= 7'h0;
            count_bad <= 1'b0;
            parity_seen <= 1'b0;
            state <= tape_seq_pkg::st_rd_word;
          end
          tape_seq_pkg::st_rd_word: begin
            // gaps and blank tape give no words, the unit just waits
            if (rd_valid) begin
              wi <= wi + 7'h1;
              if (!rd_digit_ok) begin
                count_bad <= 1'b1;
              end
              if (rd_parity_err) begin
                parity_seen <= 1'b1;
              end
              mem_wdata <= word_mod(rd_word, cmd[`CMD_MOD_BIT], breg);
              if (wi == 7'h0) begin
                kk <= bcd2_count(rd_word[39:32]);
                // end-of-tape takes precedence over control marker
                ctl_blk <= (rd_word[43:40] == `SIGN_CTRL_BLOCK) && !rd_eot_block;
                eot_blk <= rd_eot_block;
                state <= tape_seq_pkg::st_rd_store;
              end else if (eot_blk) begin
                // control word kept, rest of block not stored
                if (wi == 7'h1) begin
                  cw <= rd_word;
                end
              end else if (ctl_blk && wi == kk) begin
                // last word stays as control word
                cw <= rd_word;
              end else begin
                state <= tape_seq_pkg::st_rd_store;
              end
            end else if (rd_block_end) begin
              state <= tape_seq_pkg::st_rd_end;
            end
          end
          tape_seq_pkg::st_rd_store: begin
            if (mem_ack) begin
              // preface at L, data at L+1 up to L+kk
              addr <= bcd_add(addr, 16'h0001);
              state <= tape_seq_pkg::st_rd_word;
            end
          end
          tape_seq_pkg::st_rd_end: begin
            if (count_bad || (!eot_blk && wi != kk + 7'h1)) begin
              // two retries, then alarm at failing block
              tape_back <= 1'b1;
              if (tries < `MAX_RETRIES) begin
                tries <= tries + 2'h1;
                addr <= blk_start;
                state <= tape_seq_pkg::st_rd_go;
              end else begin
                alarm <= tape_seq_pkg::alarm_count;
                busy <= 1'b0;
                state <= tape_seq_pkg::st_idle;
              end
            end else if (parity_seen) begin
              // data already stored, back up to reread
              tape_back <= 1'b1;
              alarm <= tape_seq_pkg::alarm_parity;
              busy <= 1'b0;
              state <= tape_seq_pkg::st_idle;
            end else if (ctl_blk || eot_blk) begin
              // save P and C, jump through modified last field
              cw <= {cw_mod[43:32], preg, cw_mod[15:0]};
              saved_c <= creg;
              preg <= cw_mod[15:0];
              busy <= 1'b0;
              // head already past the causing block
              state <= tape_seq_pkg::st_idle;
            end else begin
              tries <= 2'h0;
              blocks <= blocks - 7'h1;
              if (blocks == 7'h1) begin
                busy <= 1'b0;
                state <= tape_seq_pkg::st_idle;
              end else begin
                state <= tape_seq_pkg::st_rd_go;
              end
            end
          end
          tape_seq_pkg::st_wr_pref: begin
            if (mem_ack) begin
              // preface taken from digits one and two
              kk <= bcd2_count(mem_rdata[39:32]);
              wr_word <= mem_rdata;
              addr <= bcd_add(addr, 16'h0001);
              // length below ten words stops before motion
              if (bcd2_count(mem_rdata[39:32]) < `WORDS_MIN) begin
                alarm <= tape_seq_pkg::alarm_length;
                busy <= 1'b0;
                state <= tape_seq_pkg::st_idle;
              end else begin
                state <= tape_seq_pkg::st_wr_go;
              end
            end
          end
          tape_seq_pkg::st_wr_go: begin
            tape_fwd <= 1'b1;
            wi <= 7'h0;
            // own preface ahead of the first word
            if (op == `OP_IW_FIXED) begin
              wr_word <= {4'h0, instr[23:16], 32'h0};
            end
            wr_valid <= 1'b1;
            state <= tape_seq_pkg::st_wr_send;
          end
          tape_seq_pkg::st_wr_send: begin
            if (wr_ready) begin
              wr_valid <= 1'b0;
              if (wi == kk) begin
                wr_block_end <= 1'b1;
                state <= tape_seq_pkg::st_wr_next;
              end else begin
                state <= tape_seq_pkg::st_wr_fetch;
              end
            end
          end
          tape_seq_pkg::st_wr_fetch: begin
            if (mem_ack) begin
              wr_word <= mem_rdata;
              wr_valid <= 1'b1;
              wi <= wi + 7'h1;
              addr <= bcd_add(addr, 16'h0001);
              state <= tape_seq_pkg::st_wr_send;
            end
          end
          tape_seq_pkg::st_wr_next: begin
            blocks <= blocks - 7'h1;
            // fixed write stops at the marker, head at physical end
            if (blocks == 7'h1 || (eot_seen && op == `OP_IW_FIXED)) begin
              busy <= 1'b0;
              state <= tape_seq_pkg::st_idle;
            end else if (op == `OP_IW_PREFACE) begin
              state <= tape_seq_pkg::st_wr_pref;
            end else begin
              state <= tape_seq_pkg::st_wr_go;
            end
          end
          default: state <= tape_seq_pkg::st_idle;
        endcase
      end
    end
  end
endmodule

// file: dv/tape_seq_assertions.sv
// port-level checker for the tape block sequencer
`timescale 1ns/1ns
module tape_seq_assertions (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // storage
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  // tape unit
  input wire logic tape_fwd,
  input wire logic tape_back,
  input wire logic unit_write_ok,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [43:0] wr_word,
  input wire logic wr_block_end
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  logic [7:0] blk_words;
  // words sent since the last block end, preface included
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_words <= 8'h0;
    end else if (wr_block_end) begin
      blk_words <= 8'h0;
    end else if (wr_valid && wr_ready) begin
      blk_words <= blk_words + 8'h1;
    end
  end
  a_wait_first: assert property ((avs_read || avs_write) && !$past(avs_read) && !$past(avs_write)
    |-> avs_waitrequest) else $error("access missed its wait state");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access waited too long");
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we)) else $error("storage request changed before ack");
  a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable(wr_word))
    else $error("tape word dropped while stalled");
  a_end_pulse: assert property (wr_block_end |=> !wr_block_end)
    else $error("block end longer than one cycle");
  a_blk_length: assert property (wr_block_end |-> blk_words >= 8'h0b && blk_words <= 8'h65)
    else $error("written block length out of range");
  a_ring_guard: assert property (wr_valid |-> unit_write_ok)
    else $error("write offered to unit without ring");
  a_move_excl: assert property (!(tape_fwd && tape_back))
    else $error("forward and backward together");
  a_fwd_pulse: assert property (tape_fwd |=> !tape_fwd)
    else $error("forward pulse too long");
  // main scenarios reached
  cover property (wr_block_end);
  cover property (mem_req && mem_we && mem_ack);
  cover property (avs_read && !avs_waitrequest);
endmodule
bind tape_seq tape_seq_assertions i_chk (.*);

// file: dv/tape_unit_model.sv
// behavioural tape unit: block reader, write sink, marker and ring
`timescale 1ns/1ns
module tape_unit_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // unit control and status
  input wire logic tape_fwd,
  input wire logic tape_write_mode,
  output logic unit_ready,
  output logic unit_write_ok,
  output logic unit_eot_mark,
  // read stream
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [43:0] rd_word,
  output logic rd_digit_ok,
  output logic rd_parity_err,
  output logic rd_eot_block,
  output logic rd_block_end,
  // write stream
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [43:0] wr_word,
  input wire logic wr_block_end
);
  logic ring = 1'b1;
  int eot_at = 1000;
  int blocks = 0;
  int rb = 0;
  logic [43:0] wq[$];
  logic [43:0] w;
  assign unit_ready = 1'b1;
  logic dig_ok = 1'b1;
  assign rd_digit_ok = dig_ok;
  assign rd_parity_err = 1'b0;
  assign rd_eot_block = 1'b0;
  assign unit_write_ok = ring;
  initial begin
    rd_valid = 1'b0;
    rd_word = 44'h0;
    rd_block_end = 1'b0;
    wr_ready = 1'b0;
    unit_eot_mark = 1'b0;
  end
  // block 1 is a control block, one data word of block 0 carries sign 8
  function automatic logic [43:0] blk_word(input int b, input int j);
    if (j == 0) return {b == 1 ? 4'h7 : 4'h0, 8'h10, 32'h0};
    if (b == 1 && j == 10) return {28'h0777, 16'h1234};
    return {b == 0 && j == 3 ? 4'h8 : 4'h0, 32'h0, 4'(b), 4'(j - 1)};
  endfunction
  // idle gap after every odd word and after the last; released data is inverted, not held
  always @(posedge core_clk) begin
    if (tape_fwd && !tape_write_mode) begin
      for (int j = 0; j <= 10; j++) begin
        w = blk_word(rb, j);
        rd_word <= w;
        rd_valid <= 1'b1;
        do @(posedge core_clk); while (rd_ready !== 1'b1);
        if (j % 2 == 1 || j == 10) begin
          rd_valid <= 1'b0;
          rd_word <= ~w;
          @(posedge core_clk);
        end
      end
      // end mark held until the sequencer waits for words again
      rd_block_end <= 1'b1;
      do @(posedge core_clk); while (rd_ready !== 1'b1);
      rd_block_end <= 1'b0;
      rb++;
    end
  end
  // sink stalls every other cycle; marker follows blocks written
  always @(posedge core_clk) begin
    wr_ready <= ~wr_ready;
    if (wr_valid && wr_ready) wq.push_back(wr_word);
    if (wr_block_end) blocks++;
    unit_eot_mark <= blocks >= eot_at;
  end
endmodule

// file: dv/tb.sv
// self-checking bench for the tape block sequencer
`timescale 1ns/1ns
module tb;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [5:0] avs_address = 6'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, st;
  logic avs_waitrequest, mem_req, mem_we, mem_ack = 1'b0;
  logic [15:0] mem_addr;
  logic [43:0] mem_wdata, mem_rdata = 44'h0, rd_word, wr_word;
  logic [3:0] unit_sel;
  logic tape_fwd, tape_back, tape_write_mode, unit_ready, unit_write_ok, unit_eot_mark;
  logic rd_valid, rd_ready, rd_digit_ok, rd_parity_err, rd_eot_block, rd_block_end;
  logic wr_valid, wr_ready, wr_block_end;
  logic [43:0] mem [0:255];
  int mismatches = 0;
  int num_checks = 0;
  int backs = 0;
  tape_seq i_dut (.*);
  tape_unit_model i_tape (.*);
  always #5 core_clk = ~core_clk;
  // backward moves asked of the unit
  always @(posedge core_clk) if (tape_back) backs++;
  // storage acks one cycle after a request; idle data keeps changing
  always @(posedge core_clk) begin
    mem_ack <= mem_req && !mem_ack;
    if (mem_req && mem_ack && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
    if (mem_req && !mem_ack) begin
      mem_rdata <= mem[mem_addr[7:0]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
  function automatic logic [7:0] ba(input int n);
    return 8'((n / 10) * 16 + n % 10);
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic give_up;
    mismatches++;
    $display("timeout at %0t", $time);
    complete_run();
  endtask
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    if (!w) st = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (k >= 20) give_up();
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  // start an operation and poll busy until it drops
  task automatic run(input logic [31:0] ins, input logic [8:0] cmd);
    int k;
    k = 0;
    wr(6'h04, ins);
    wr(6'h00, {23'h0, cmd});
    do begin
      rd(6'h14);
      k++;
    end while (st[0] !== 1'b0 && k < 2000);
    if (k >= 2000) give_up();
  endtask
  task automatic t_regs;
    rd(6'h14);
    chk(st, 44'h0);
    wr(6'h3c, 32'hffff);
    rd(6'h3c);
    chk(st, 44'h0);
    wr(6'h08, 32'h0020);
    rd(6'h08);
    chk(st, 44'h20);
    $display("test regs done");
  endtask
  // three blocks asked, second is a control block, so reading stops early
  task automatic t_read;
    wr(6'h0c, 32'h0555);
    mem[ba(81)] = 44'habc;
    run({4'h0, 4'h3, 8'h00, 16'h0060}, 9'h159);
    chk(st[5:0], 44'h0);
    chk(44'(unit_sel), 44'h5);
    chk(mem[ba(60)], {4'h0, 8'h10, 32'h0});
    for (int k = 0; k < 10; k++) chk(mem[ba(61 + k)], {36'h0, k == 2 ? 8'h22 : 8'(k)});
    chk(mem[ba(71)], {4'h7, 8'h10, 32'h0});
    for (int k = 0; k < 9; k++) chk(mem[ba(72 + k)], {36'h0, 4'h1, 4'(k)});
    chk(mem[ba(81)], 44'habc);
    chk(44'(i_tape.rb), 44'h2);
    rd(6'h0c);
    chk(st, 44'h1234);
    rd(6'h18);
    chk(st, 44'h0555_1234);
    $display("test read done");
  endtask
  // every word fails its digit check: two retries, then the count alarm
  task automatic t_retry;
    int r0;
    int b0;
    r0 = i_tape.rb;
    b0 = backs;
    i_tape.dig_ok = 1'b0;
    run({4'h0, 4'h1, 8'h00, 16'h0100}, 9'h009);
    i_tape.dig_ok = 1'b1;
    chk(st[5:3], tape_seq_pkg::alarm_count);
    chk(44'(backs - b0), 44'h3);
    chk(44'(i_tape.rb - r0), 44'h3);
    $display("test retry done");
  endtask
  task automatic t_fixed(input logic [3:0] n, input logic [7:0] kk, input int words, input int blks,
    input logic [2:0] alarm);
    i_tape.wq.delete();
    i_tape.blocks = 0;
    run({4'h0, n, kk, 16'h0000}, 9'h00a);
    chk(st[5:3], alarm);
    chk(44'(i_tape.wq.size()), 44'(words));
    chk(44'(i_tape.blocks), 44'(blks));
    if (words > 0) begin
      chk(i_tape.wq[0], {4'h0, kk, 32'h0});
      chk(i_tape.wq[1], mem[0]);
      chk(i_tape.wq[words - 1], mem[8'h99]);
    end
    $display("test fixed write done");
  endtask
  task automatic t_pref;
    i_tape.wq.delete();
    i_tape.blocks = 0;
    mem[ba(40)] = {4'h0, 8'h12, 32'h0};
    mem[ba(53)] = {4'h0, 8'h10, 32'h0};
    run({4'h0, 4'h2, 8'h00, 16'h0040}, 9'h00b);
    chk(44'(i_tape.wq.size()), 44'h18);
    chk(44'(i_tape.blocks), 44'h2);
    chk(i_tape.wq[1], mem[ba(41)]);
    chk(i_tape.wq[14], mem[ba(54)]);
    $display("test preface write done");
  endtask
  task automatic t_eot;
    i_tape.blocks = 0;
    i_tape.eot_at = 1;
    run({4'h0, 4'h3, 8'h10, 16'h0000}, 9'h00a);
    chk(st[7], 1'b1);
    i_tape.wq.delete();
    run({4'h0, 4'h3, 8'h10, 16'h0000}, 9'h00a);
    chk(st[5:3], tape_seq_pkg::alarm_eot);
    chk(44'(i_tape.wq.size()), 44'h0);
    i_tape.eot_at = 1000;
    wr(6'h00, 32'h10);
    rd(6'h14);
    chk(st[7], 1'b0);
    $display("test end of tape done");
  endtask
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = {36'h0, 8'(i)};
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_read();
    t_retry();
    t_fixed(4'h0, 8'h10, 110, 10, tape_seq_pkg::alarm_none);
    t_fixed(4'h1, 8'h00, 101, 1, tape_seq_pkg::alarm_none);
    t_fixed(4'h1, 8'h09, 0, 0, tape_seq_pkg::alarm_length);
    i_tape.ring = 1'b0;
    t_fixed(4'h1, 8'h10, 0, 0, tape_seq_pkg::alarm_no_write);
    i_tape.ring = 1'b1;
    t_pref();
    t_eot();
    complete_run();
  end
endmodule
